/* File: rtl/eeprom_prot_pkg.sv */
// Package for the protected EEPROM controller: register map, field
// positions, protection encodings and timing constants.
// Assumes a 25 MHz register clock and a 32-bit AXI4-Lite register bus.
package eeprom_prot_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_ADDR       = 8'h00; // Byte offset of access
    localparam logic [7:0] OFF_DATA       = 8'h04; // Data word read or write
    localparam logic [7:0] OFF_STATUS     = 8'h08; // Engine status bits
    localparam logic [7:0] OFF_BLKSEL     = 8'h0c; // Block selector
    localparam logic [7:0] OFF_PROT       = 8'h10; // Protection of selected block
    localparam logic [7:0] OFF_PASS       = 8'h14; // Password set
    localparam logic [7:0] OFF_UNLOCK     = 8'h18; // Unlock attempt
    localparam logic [7:0] OFF_LOCK       = 8'h1c; // Lock command
    localparam logic [7:0] OFF_HIDE       = 8'h20; // Hide command
    localparam logic [7:0] OFF_SIZE       = 8'h24; // Storage size in bytes
    localparam logic [7:0] OFF_BLKCNT     = 8'h28; // Number of blocks
    localparam logic [7:0] OFF_INIT       = 8'h2c; // Initialisation outcome
    localparam logic [7:0] OFF_INT_EN     = 8'h30; // Interrupt enable
    localparam logic [7:0] OFF_INT_RAW    = 8'h34; // Raw flag, write 1 clears
    localparam logic [7:0] OFF_INT_MASKED = 8'h38; // Masked flag
    localparam logic [7:0] OFF_MODE       = 8'h3c; // Bit 0: privileged access
    localparam logic [7:0] OFF_BLKOF      = 8'h40; // Block index of ADDR

    // ==========================================================
    // Status bit positions
    localparam int ST_LOW_VOLT  = 0;
    localparam int ST_DENIED    = 1;
    localparam int ST_COPYING   = 2;
    localparam int ST_ERASING   = 3;
    localparam int ST_ACTIVE    = 4;
    localparam int ST_RDWR_BUSY = 5;

    // ==========================================================
    // Protection field: bits 1:0 level, bit 3 privileged-only
    localparam logic [1:0] PROT_READWRITE_LOCKED_READONLY = 2'h0;
    localparam logic [1:0] PROT_ACCESS_ONLY_WHEN_UNLOCKED = 2'h1;
    localparam logic [1:0] PROT_READONLY_LOCKED_NONE      = 2'h2;
    localparam int         PROT_PRIV_BIT                  = 3;

    // Initialisation outcome codes
    localparam logic [1:0] INIT_CLEAN = 2'h0;
    localparam logic [1:0] INIT_RETRY = 2'h1;
    localparam logic [1:0] INIT_FAIL  = 2'h2;

    // ==========================================================
    // Timing: write phases in ns, converted to cycles of 40 ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int COPY_TIME_NS  = 400;
    localparam int ERASE_TIME_NS = 400;
    localparam int PROG_TIME_NS  = 800;
    localparam int COPY_CYC  = (COPY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write engine states
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_COPY,
        ENG_ERASE,
        ENG_PROG
    } eng_state_t;

endpackage

/* File: rtl/eeprom_prot_ctrl.sv */
// Protected word storage controller with per-block protection, write
// engine status and a program interrupt, reached over AXI4-Lite.
// Assumes one 25 MHz clock, synchronous active-low reset, synchronous
// inputs and a master keeping one read and one write in flight.
`timescale 1ns/1ps
`default_nettype none

module eeprom_prot_ctrl
    import eeprom_prot_pkg::*;
#(
    parameter int WORDS  = 64,   // Storage words
    parameter int BLOCKS = 4     // Blocks of equal size
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address channel
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // Write response channel
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // Read data channel
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Supply and power-fail recovery indications
    input  wire logic        supply_low,
    input  wire logic        prior_write_torn,
    input  wire logic        torn_unrecoverable,
    // Interrupt
    output var  logic        prog_irq
);
    import eeprom_prot_pkg::*;

    // ==========================================================
    // Geometry
    localparam int BW = $clog2(BLOCKS);
    localparam int AW = $clog2(WORDS);
    localparam int WPB = WORDS / BLOCKS;
    localparam logic [31:0] SIZE_BYTES = 32'(WORDS * 4);

    // Byte offset to block index, shared by access and read-back
    function automatic logic [BW-1:0] block_of(input logic [31:0] off);
        block_of = BW'((off >> 2) / WPB);
    endfunction

    // ==========================================================
    // State
    logic [31:0]      mem [WORDS];        // Storage cells
    logic [31:0]      addr_q;             // Byte offset register
    logic [BW-1:0]    blksel_q;           // Selected block
    logic [3:0]       prot_q   [BLOCKS];  // Protection per block
    logic [31:0]      pass_q   [BLOCKS];  // Password per block
    logic [BLOCKS-1:0] has_pw_q;          // Password committed
    logic [BLOCKS-1:0] locked_q;          // Lock state
    logic [BLOCKS-1:0] hidden_q;          // Hidden until reset
    logic             priv_q;             // Privileged mode of accessor
    logic [5:0]       status_q;           // Engine status bits
    logic [1:0]       init_q;             // Init outcome
    logic             init_done_q;        // Strap captured after reset
    logic             int_en_q;           // Interrupt enable
    logic             int_raw_q;          // Sticky done flag
    eng_state_t       eng_q;              // Write engine
    logic [7:0]       cnt_q;              // Phase counter
    logic [AW-1:0]    pend_idx_q;         // Pending word index
    logic [31:0]      pend_data_q;        // Pending word data

    // ==========================================================
    // Access permission for a byte offset
    function automatic logic [1:0] perm(input logic [31:0] off);
        logic [BW-1:0] b;
        logic [3:0]    p;
        logic          lk;
        logic          rd;
        logic          wr;
        b  = block_of(off);
        p  = (b == '0) ? prot_q[0] : (prot_q[0] | prot_q[b]);
        lk = has_pw_q[b] && locked_q[b];
        // Every arm sets both bits; level 0 and the unused code 3 take the default arm
        case (p[1:0])
            PROT_ACCESS_ONLY_WHEN_UNLOCKED: {wr, rd} = {2{has_pw_q[b] && !locked_q[b]}};
            PROT_READONLY_LOCKED_NONE:      {wr, rd} = {1'b0, !lk};
            default:                        {wr, rd} = {!lk, 1'b1};
        endcase
        // Supervisor, block zero lock, hiding and range override the level
        if ((p[PROT_PRIV_BIT] && !priv_q) ||
            (b != '0 && ((has_pw_q[0] && locked_q[0]) || hidden_q[b])) ||
            ((off >> 2) >= WORDS)) begin
            {wr, rd} = 2'b00;
        end
        perm = {wr, rd};
    endfunction

    // Control registers of a block other than zero hidden by block zero lock or by its own hide flag
    function automatic logic ctl_ok(input logic [BW-1:0] b);
        ctl_ok = (b == '0) || !((has_pw_q[0] && locked_q[0]) || hidden_q[b]);
    endfunction

    // ==========================================================
    // AXI write handshake: capture address and data in either order
    logic [7:0]  aw_q;
    logic        aw_have_q;
    logic [31:0] w_q;
    logic        w_have_q;
    logic        wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_q          <= '0;
            w_q           <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            // Accept one beat of each, hold until the write executes
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready  <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_q          <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_q          <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_q[1:0] == 2'h0 && aw_q <= OFF_BLKOF) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Register writes and protection state
    logic [BW-1:0] wb;
    assign wb = blksel_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q   <= '0;
            blksel_q <= '0;
            priv_q   <= 1'b0;
            int_en_q <= 1'b0;
            has_pw_q <= '0;
            locked_q <= '0;
            hidden_q <= '0;
            for (int i = 0; i < BLOCKS; i++) begin
                prot_q[i] <= '0;
                pass_q[i] <= '0;
            end
        end else if (wr_go) begin
            case (aw_q)
                OFF_ADDR:   addr_q   <= w_q;
                OFF_BLKSEL: blksel_q <= BW'(w_q);
                OFF_MODE:   priv_q   <= w_q[0];
                OFF_INT_EN: int_en_q <= w_q[0];
                OFF_PROT: if (ctl_ok(wb)) begin
                    prot_q[wb] <= w_q[3:0];
                end
                OFF_PASS: if (ctl_ok(wb) && !has_pw_q[wb]) begin
                    pass_q[wb]   <= w_q;
                    has_pw_q[wb] <= 1'b1;
                    locked_q[wb] <= 1'b0;
                end
                OFF_UNLOCK: if (ctl_ok(wb) && has_pw_q[wb] && w_q == pass_q[wb]) begin
                    locked_q[wb] <= 1'b0;
                end
                OFF_LOCK: if (has_pw_q[wb]) begin
                    locked_q[wb] <= 1'b1;
                end
                OFF_HIDE: if (wb != '0) begin
                    hidden_q[wb] <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Write engine: copy, erase, program phases
    logic [1:0] wperm;
    // Procedural so that protection changes re-evaluate it, not only the offset
    always_comb wperm = perm(addr_q);
    logic data_wr;
    assign data_wr = wr_go && aw_q == OFF_DATA;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_q       <= ENG_IDLE;
            cnt_q       <= '0;
            pend_idx_q  <= '0;
            pend_data_q <= '0;
        end else begin
            case (eng_q)
                ENG_IDLE: if (data_wr && wperm[1] && !supply_low) begin
                    // Ignoring writes while busy relies on software pacing
                    eng_q       <= ENG_COPY;
                    cnt_q       <= 8'(COPY_CYC - 1);
                    pend_idx_q  <= AW'(addr_q >> 2);
                    pend_data_q <= w_q;
                end
                ENG_COPY: if (cnt_q == '0) begin
                    eng_q <= ENG_ERASE;
                    cnt_q <= 8'(ERASE_CYC - 1);
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                ENG_ERASE: if (cnt_q == '0) begin
                    eng_q <= ENG_PROG;
                    cnt_q <= 8'(PROG_CYC - 1);
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                ENG_PROG: if (cnt_q == '0) begin
                    eng_q <= ENG_IDLE;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                default: eng_q <= ENG_IDLE;
            endcase
        end
    end

    // Storage cells update when programming completes
    always_ff @(posedge aclk) begin
        if (eng_q == ENG_PROG && cnt_q == '0 && !supply_low) begin
            mem[pend_idx_q] <= pend_data_q;
        end
    end

    // ==========================================================
    // Status bits: errors sticky until the next data or password write
    logic rd_go;
    logic prog_done;
    assign prog_done = eng_q == ENG_PROG && cnt_q == '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
        end else begin
            status_q[ST_COPYING] <= eng_q == ENG_COPY;
            status_q[ST_ERASING] <= eng_q == ENG_ERASE;
            status_q[ST_ACTIVE]  <= eng_q != ENG_IDLE;
            if (data_wr || (wr_go && aw_q == OFF_PASS)) begin
                status_q[ST_DENIED]   <= 1'b0;
                status_q[ST_LOW_VOLT] <= 1'b0;
                status_q[ST_RDWR_BUSY] <= 1'b0;
            end
            if ((data_wr && !wperm[1]) ||
                (wr_go && aw_q == OFF_PASS && (has_pw_q[wb] || !ctl_ok(wb)))) begin
                status_q[ST_DENIED] <= 1'b1;
            end
            if ((data_wr && wperm[1] && eng_q == ENG_IDLE && supply_low) ||
                (prog_done && supply_low)) begin
                status_q[ST_LOW_VOLT] <= 1'b1;
            end
            if (rd_go && s_axi_araddr == OFF_DATA && eng_q != ENG_IDLE) begin
                status_q[ST_RDWR_BUSY] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Init outcome captured after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_q      <= INIT_CLEAN;
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            init_done_q <= 1'b1;
            if (prior_write_torn) begin
                init_q <= torn_unrecoverable ? INIT_FAIL : INIT_RETRY;
            end else begin
                init_q <= INIT_CLEAN;
            end
        end
    end

    // ==========================================================
    // Program interrupt: set on completion, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_raw_q <= 1'b0;
            prog_irq  <= 1'b0;
        end else begin
            int_raw_q <= prog_done ||
                         (int_raw_q && !(wr_go && aw_q == OFF_INT_RAW && w_q[0]));
            prog_irq <= int_raw_q && int_en_q;
        end
    end

    // ==========================================================
    // Read channel: one-cycle decode
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= '0;
                case (s_axi_araddr)
                    OFF_ADDR:   s_axi_rdata <= addr_q;
                    OFF_DATA: if (wperm[0] && eng_q == ENG_IDLE) begin
                        s_axi_rdata <= mem[AW'(addr_q >> 2)];
                    end else begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                    OFF_STATUS: s_axi_rdata <= 32'(status_q);
                    OFF_BLKSEL: s_axi_rdata <= 32'(blksel_q);
                    OFF_PROT:   s_axi_rdata <= ctl_ok(wb) ? 32'(prot_q[wb]) : '0;
                    OFF_LOCK:   s_axi_rdata <= 32'(!(has_pw_q[wb] && locked_q[wb]));
                    OFF_SIZE:   s_axi_rdata <= SIZE_BYTES;
                    OFF_BLKCNT: s_axi_rdata <= 32'(BLOCKS);
                    OFF_INIT:   s_axi_rdata <= 32'(init_q);
                    OFF_INT_EN: s_axi_rdata <= 32'(int_en_q);
                    OFF_INT_RAW: s_axi_rdata <= 32'(int_raw_q);
                    OFF_INT_MASKED: s_axi_rdata <= 32'(int_raw_q && int_en_q);
                    OFF_MODE:   s_axi_rdata <= 32'(priv_q);
                    OFF_BLKOF:  s_axi_rdata <= 32'(block_of(addr_q));
                    OFF_PASS, OFF_UNLOCK, OFF_HIDE: s_axi_rdata <= '0;
                    default:    s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/eeprom_prot_checker.sv */
// Checks bus handshake timing and reset quiet of the controller.
// Bound to the controller and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module eeprom_prot_checker
    import eeprom_prot_pkg::*;
(
    // Clock, reset, write channels
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels, interrupt
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        prog_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Taken requests; the bench offers both write channels at once
    sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    a_b_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_aw_single: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    a_r_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_ar_single: assert property (rd_taken |=> !s_axi_arready)
        else $error("read address taken twice");
    a_rd_unmapped: assert property (rd_taken ##0 (s_axi_araddr > OFF_BLKOF) |=>
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR) else $error("unmapped read accepted");
    a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !prog_irq)
        else $error("output active after reset");
endmodule
bind eeprom_prot_ctrl eeprom_prot_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_irq);
`default_nettype wire

/* File: tb/eeprom_prot_ctrl_tb.sv */
// Self-checking bench: register bus, supply and recovery pins.
// Assumes the checker file is compiled first and binds itself.
`timescale 1ns/1ps
`default_nettype none
module eeprom_prot_ctrl_tb;
    import eeprom_prot_pkg::*;
    // ==========================================================
    // Signals
    localparam logic [1:0] OK = RESP_OKAY;
    localparam logic [1:0] ER = RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0, low = 1'b0, torn = 1'b0, bad = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, m, m2;
    logic [1:0] bresp, rresp;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [33:0] exp_r[$]; // Noted read results
    logic [1:0] exp_b[$]; // Noted write responses
    int fail_count = 0, check_count = 0, i, n;
    logic [1:0] lv[3] = '{PROT_READWRITE_LOCKED_READONLY, PROT_ACCESS_ONLY_WHEN_UNLOCKED,
        PROT_READONLY_LOCKED_NONE};
    bit rok[3] = '{1, 0, 1}, wok[3] = '{1, 0, 0}, lok[3] = '{1, 0, 0};
    always #20 aclk = ~aclk;
    eeprom_prot_ctrl #(.WORDS(64), .BLOCKS(4)) i_eeprom_prot_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .supply_low(low), .prior_write_torn(torn), .torn_unrecoverable(bad), .prog_irq(irq));
    // ==========================================================
    // Helpers
    task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded waits end the run rather than hang it
    task automatic guard;
        if (n >= 50) begin
            fail_count++;
            complete_run;
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge aclk);
    endtask
    // One write; k + 1 cycles after it let the write engine finish
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e = OK, int k = 45);
        exp_b.push_back(e);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; n = 0;
        do begin
            @(posedge aclk); n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (((awvalid && !awready) || (wvalid && !wready)) && n < 50);
        while (!bvalid && n < 50) begin @(posedge aclk); n++; end
        guard; bready <= 1'b0; cyc(k + 1);
    endtask
    task automatic rd(logic [7:0] a, logic [1:0] e, logic [31:0] d);
        exp_r.push_back({e, d});
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0;
        do begin @(posedge aclk); n++; end while (!arready && n < 50);
        arvalid <= 1'b0;
        while (!rvalid && n < 50) begin @(posedge aclk); n++; end
        guard; rready <= 1'b0; cyc(1);
    endtask
    task automatic rst;
        aresetn <= 1'b0; cyc(10); aresetn <= 1'b1; cyc(1);
    endtask
    // Results meet the oldest note as they appear
    always @(posedge aclk) begin
        if (rvalid && rready) chk("read", {rresp, rdata}, exp_r.pop_front());
        if (bvalid && bready) chk("bresp", 34'(bresp), 34'(exp_b.pop_front()));
    end
    // ==========================================================
    // Scenarios
    initial begin
        v = $urandom(32'h5c3dfe8a);
        rst;
        rd(OFF_SIZE, OK, 32'h100);
        rd(OFF_BLKCNT, OK, 32'h4);
        rd(OFF_INIT, OK, 32'h0);
        rd(8'h44, ER, 32'h0);
        wr(8'h48, 32'h0, ER);
        wr(OFF_MODE, 32'h1); wr(OFF_ADDR, 32'h44);
        rd(OFF_BLKOF, OK, 32'h1);
        m = $urandom; wr(OFF_DATA, m, OK, 0);
        rd(OFF_STATUS, OK, 32'h14);
        rd(OFF_DATA, ER, 32'h0);
        cyc(5);
        rd(OFF_STATUS, OK, 32'h38);
        cyc(30);
        rd(OFF_INT_MASKED, OK, 32'h0);
        rd(OFF_INT_RAW, OK, 32'h1);
        wr(OFF_INT_EN, 32'h1); chk("irq", 34'(irq), 34'h1);
        wr(OFF_INT_RAW, 32'h1); chk("irq", 34'(irq), 34'h0);
        rd(OFF_DATA, OK, m);
        wr(OFF_BLKSEL, 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(OFF_PROT, 32'(lv[i])); v = $urandom; wr(OFF_DATA, v);
            if (wok[i]) m = v;
            rd(OFF_STATUS, OK, wok[i] ? 32'h0 : 32'h2);
            rd(OFF_DATA, rok[i] ? OK : ER, rok[i] ? m : 32'h0);
        end
        wr(OFF_ADDR, 32'h84); wr(OFF_BLKSEL, 32'h2); m2 = $urandom; wr(OFF_DATA, m2);
        wr(OFF_PASS, 32'h1234);
        rd(OFF_LOCK, OK, 32'h1);
        wr(OFF_PASS, 32'h99);
        rd(OFF_STATUS, OK, 32'h2);
        for (i = 0; i < 3; i++) begin
            wr(OFF_PROT, 32'(lv[i])); wr(OFF_LOCK, 32'h1); wr(OFF_DATA, $urandom);
            rd(OFF_STATUS, OK, 32'h2);
            rd(OFF_DATA, lok[i] ? OK : ER, lok[i] ? m2 : 32'h0);
            wr(OFF_UNLOCK, 32'h1234);
        end
        rd(OFF_LOCK, OK, 32'h1);
        wr(OFF_PROT, 32'h8); wr(OFF_MODE, 32'h0);
        rd(OFF_DATA, ER, 32'h0);
        wr(OFF_MODE, 32'h1);
        rd(OFF_DATA, OK, m2);
        low <= 1'b1; wr(OFF_DATA, 32'h0);
        rd(OFF_STATUS, OK, 32'h1);
        low <= 1'b0; wr(OFF_HIDE, 32'h2);
        rd(OFF_DATA, ER, 32'h0);
        wr(OFF_ADDR, 32'h44); wr(OFF_BLKSEL, 32'h0); wr(OFF_PASS, 32'h5); wr(OFF_LOCK, 32'h1);
        rd(OFF_DATA, ER, 32'h0);
        wr(OFF_UNLOCK, 32'h5);
        rd(OFF_DATA, OK, m);
        torn <= 1'b1; rst;
        rd(OFF_INIT, OK, 32'h1);
        bad <= 1'b1; rst;
        rd(OFF_INIT, OK, 32'h2);
        torn <= 1'b0; bad <= 1'b0; rst;
        rd(OFF_INIT, OK, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
